// >>> rtl/irq_time_base.v
/*
 * Interrupt request flags, enables, grouped interrupts, time base
 * dividers, wake-up detection and vector request to the core.
 * Assumes event inputs are one-cycle pulses synchronous to sys_clk_in
 * and that the core answers a request with a one-cycle acknowledge.
 */
// Decided for this implementation: the register addresses and the strobed register port.
// How it works
// - Protection fault sets its flag; vector needs global and protection enable.
// - Servicing protection clears its flag and the global enable.
// - Conversion done sets its flag; vector needs global and conversion enable.
// - Servicing conversion clears its flag and the global enable.
// - Four group flags: 0-2 set by their timer group events, 3 when its enabled source term rises.
// - Servicing an enabled group calls its vector, clears group flag and global.
// - Group service leaves source flags set; software clears them.
// - Each time base overflow sets its flag; vector needs global and its enable.
// - Servicing a time base clears its flag and the global enable.
// - Time base control bit 7 runs or stops both dividers.
// - Bit 6 picks the dedicated clock or system clock over four.
// - Bits 5:4 give the second time base 2^12 to 2^15 input clocks.
// - Bits 2:0 give the first time base 2^(8+code) input clocks.
// - EEPROM write end sets its flag; needs global, own and group three enable.
// - EEPROM service clears group flag and global only; software clears source.
// - Low supply sets its flag; needs global, own and group three enable.
// - Low supply service clears group flag and global only; flag persists.
// - Touch slot overflow sets its flag; needs global and touch enable.
// - Servicing touch clears its flag and the global enable.
// - Flags set regardless of enables, except group three's; cleared global enable blocks every vector.
// - No request is offered from the cycle after the return stack becomes full.
// - Any flag rising from low to high wakes the device.
`timescale 1ns/1ps
`include "irq_tb_defines.vh"

module irq_time_base (
    input wire sys_clk_in,
    input wire reset_n_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_write_in,
    input wire reg_read_in,
    output reg [7:0] reg_rdata_out,
    input wire protection_fault_in,
    input wire conversion_done_in,
    input wire touch_slot_overflow_in,
    input wire eeprom_write_done_in,
    input wire low_supply_detect_in,
    input wire [2:0] timer_group_event_in,
    input wire interval_dedicated_clock_in,
    input wire stack_full_in,
    input wire irq_ack_in,
    input wire return_enable_in,
    output reg irq_request_out,
    output reg [3:0] irq_vector_out,
    output reg wake_up_out
);

    // ****************************************************************
    // State
    // ****************************************************************
    reg global_irq_enable;
    reg protection_irq_enable;
    reg conversion_irq_enable;
    reg touch_slot_irq_enable;
    reg protection_request_flag;
    reg conversion_done_flag;
    reg touch_slot_request_flag;
    reg [3:0] group_enable;
    reg [3:0] group_request_flag;
    reg low_supply_irq_enable;
    reg eeprom_irq_enable;
    reg low_supply_request_flag;
    reg eeprom_write_done_flag;
    reg interval0_irq_enable;
    reg interval1_irq_enable;
    reg interval0_request_flag;
    reg interval1_request_flag;
    reg [7:0] time_base_control;
    reg group3_term_prev;
    reg [`NUM_SRC+1:0] flags_prev;

    wire interval0_tick;
    wire interval1_tick;
    wire pending_any;
    wire [3:0] pending_vector;
    wire [`NUM_SRC-1:0] pending;
    wire group3_term;
    wire [3:0] group_set;
    wire [`NUM_SRC+1:0] all_flags;
    wire ack;
    wire [3:0] served_group;

    reg [7:0] next_rdata;

    // Write strobe for one register address
    function wr_hit;
        input [7:0] addr;
        input [7:0] target;
        input strobe;
        begin
            wr_hit = strobe && (addr == target);
        end
    endfunction

    // Flag update: a hardware set always beats a clear in the same cycle
    function next_flag;
        input cur;
        input hw_set;
        input sw_write;
        input sw_value;
        input hw_clear;
        begin
            if (hw_set)
                next_flag = 1'b1;
            else if (sw_write)
                next_flag = sw_value;
            else if (hw_clear)
                next_flag = 1'b0;
            else
                next_flag = cur;
        end
    endfunction

    // Acknowledge of a given vector
    function served;
        input ack_now;
        input [3:0] vec;
        input [3:0] which;
        begin
            served = ack_now && (vec == which);
        end
    endfunction

    wire wr_global = wr_hit(reg_addr_in, `ADDR_GLOBAL_CTRL, reg_write_in);
    wire wr_ctrl0 = wr_hit(reg_addr_in, `ADDR_INT_CTRL0, reg_write_in);
    wire wr_group = wr_hit(reg_addr_in, `ADDR_INT_GROUP, reg_write_in);
    wire wr_low_ee = wr_hit(reg_addr_in, `ADDR_INT_LOW_EE, reg_write_in);
    wire wr_tbc = wr_hit(reg_addr_in, `ADDR_TIME_BASE_CTRL, reg_write_in);
    wire wr_interval = wr_hit(reg_addr_in, `ADDR_INT_INTERVAL, reg_write_in);

    // Only the vector actually offered can be taken
    assign ack = irq_ack_in & irq_request_out;

    // ****************************************************************
    // Time base dividers
    // ****************************************************************
    interval_divider u_interval_divider (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .interval_dividers_on_in(time_base_control[`BIT_TB_ON]),
        .interval_clock_select_in(time_base_control[`BIT_TB_CK]),
        .interval_dedicated_clock_in(interval_dedicated_clock_in),
        .interval0_period_select_in(time_base_control[`TB0_SEL_HI:`TB0_SEL_LO]),
        .interval1_period_select_in(time_base_control[`TB1_SEL_HI:`TB1_SEL_LO]),
        .interval0_tick_out(interval0_tick),
        .interval1_tick_out(interval1_tick)
    );

    // ****************************************************************
    // Grouped interrupts
    // ****************************************************************
    // Edge of the enabled source term, so a served group does not
    // re-arm while its source flags are still standing
    assign group3_term = (low_supply_request_flag & low_supply_irq_enable) |
        (eeprom_write_done_flag & eeprom_irq_enable);
    assign group_set = {group3_term & ~group3_term_prev, timer_group_event_in};

    assign served_group = {served(ack, irq_vector_out, `SRC_GROUP3),
        served(ack, irq_vector_out, `SRC_GROUP0 + 4'h2),
        served(ack, irq_vector_out, `SRC_GROUP0 + 4'h1),
        served(ack, irq_vector_out, `SRC_GROUP0)};

    // ****************************************************************
    // Pending requests and vector selection
    // ****************************************************************
    assign pending = {
        interval1_request_flag & interval1_irq_enable,
        interval0_request_flag & interval0_irq_enable,
        group_request_flag & group_enable,
        touch_slot_request_flag & touch_slot_irq_enable,
        conversion_done_flag & conversion_irq_enable,
        protection_request_flag & protection_irq_enable
    };

    irq_priority u_irq_priority (
        .pending_in(pending),
        .any_out(pending_any),
        .vector_out(pending_vector)
    );

    assign all_flags = {low_supply_request_flag, eeprom_write_done_flag,
        interval1_request_flag, interval0_request_flag, group_request_flag,
        touch_slot_request_flag, conversion_done_flag, protection_request_flag};

    // ****************************************************************
    // Flags, enables and core handshake
    // ****************************************************************
    always @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            global_irq_enable <= 1'b0;
            protection_irq_enable <= 1'b0;
            conversion_irq_enable <= 1'b0;
            touch_slot_irq_enable <= 1'b0;
            protection_request_flag <= 1'b0;
            conversion_done_flag <= 1'b0;
            touch_slot_request_flag <= 1'b0;
            group_enable <= 4'h0;
            group_request_flag <= 4'h0;
            low_supply_irq_enable <= 1'b0;
            eeprom_irq_enable <= 1'b0;
            low_supply_request_flag <= 1'b0;
            eeprom_write_done_flag <= 1'b0;
            interval0_irq_enable <= 1'b0;
            interval1_irq_enable <= 1'b0;
            interval0_request_flag <= 1'b0;
            interval1_request_flag <= 1'b0;
            time_base_control <= `TBC_RESET;
            group3_term_prev <= 1'b0;
            flags_prev <= 11'h000;
            irq_request_out <= 1'b0;
            irq_vector_out <= `VEC_NONE;
            wake_up_out <= 1'b0;
            reg_rdata_out <= `REG_ZERO;
        end
        else
        begin
            // Any taken vector drops the global enable; a software write in
            // the same cycle loses so nesting must be re-enabled afterwards
            if (ack)
                global_irq_enable <= 1'b0;
            else if (wr_global)
                global_irq_enable <= reg_wdata_in[`BIT_GLOBAL_EN];
            else if (return_enable_in)
                global_irq_enable <= 1'b1;

            if (wr_ctrl0)
            begin
                protection_irq_enable <= reg_wdata_in[`BIT_PROT_EN];
                conversion_irq_enable <= reg_wdata_in[`BIT_CONV_EN];
                touch_slot_irq_enable <= reg_wdata_in[`BIT_TOUCH_EN];
            end
            protection_request_flag <= next_flag(protection_request_flag,
                protection_fault_in, wr_ctrl0, reg_wdata_in[`BIT_PROT_FLAG],
                served(ack, irq_vector_out, `SRC_PROT));
            conversion_done_flag <= next_flag(conversion_done_flag,
                conversion_done_in, wr_ctrl0, reg_wdata_in[`BIT_CONV_FLAG],
                served(ack, irq_vector_out, `SRC_CONV));
            touch_slot_request_flag <= next_flag(touch_slot_request_flag,
                touch_slot_overflow_in, wr_ctrl0, reg_wdata_in[`BIT_TOUCH_FLAG],
                served(ack, irq_vector_out, `SRC_TOUCH));

            if (wr_group)
                group_enable <= reg_wdata_in[`EN_HI:`EN_LO];
            group_request_flag[0] <= next_flag(group_request_flag[0], group_set[0],
                wr_group, reg_wdata_in[`FLAG_LO], served_group[0]);
            group_request_flag[1] <= next_flag(group_request_flag[1], group_set[1],
                wr_group, reg_wdata_in[`FLAG_LO + 1], served_group[1]);
            group_request_flag[2] <= next_flag(group_request_flag[2], group_set[2],
                wr_group, reg_wdata_in[`FLAG_LO + 2], served_group[2]);
            group_request_flag[3] <= next_flag(group_request_flag[3], group_set[3],
                wr_group, reg_wdata_in[`FLAG_HI], served_group[3]);
            group3_term_prev <= group3_term;

            // Source flags of group three ignore the acknowledge entirely
            if (wr_low_ee)
            begin
                low_supply_irq_enable <= reg_wdata_in[`BIT_LOW_EN];
                eeprom_irq_enable <= reg_wdata_in[`BIT_EE_EN];
            end
            low_supply_request_flag <= next_flag(low_supply_request_flag,
                low_supply_detect_in, wr_low_ee, reg_wdata_in[`BIT_LOW_FLAG],
                1'b0);
            eeprom_write_done_flag <= next_flag(eeprom_write_done_flag,
                eeprom_write_done_in, wr_low_ee, reg_wdata_in[`BIT_EE_FLAG],
                1'b0);

            if (wr_tbc)
                time_base_control <= reg_wdata_in & `TBC_WRITE_MASK;

            if (wr_interval)
            begin
                interval0_irq_enable <= reg_wdata_in[`BIT_TB0_EN];
                interval1_irq_enable <= reg_wdata_in[`BIT_TB1_EN];
            end
            interval0_request_flag <= next_flag(interval0_request_flag,
                interval0_tick, wr_interval, reg_wdata_in[`BIT_TB0_FLAG],
                served(ack, irq_vector_out, `SRC_TB0));
            interval1_request_flag <= next_flag(interval1_request_flag,
                interval1_tick, wr_interval, reg_wdata_in[`BIT_TB1_FLAG],
                served(ack, irq_vector_out, `SRC_TB1));

            // Wake on any rising flag, enabled or not
            flags_prev <= all_flags;
            wake_up_out <= |(all_flags & ~flags_prev);

            // Offer is withdrawn the cycle after the acknowledge so one request
            // yields exactly one vector
            irq_request_out <= pending_any & global_irq_enable & ~stack_full_in &
                ~ack & ~return_enable_in;
            irq_vector_out <= pending_vector;

            reg_rdata_out <= next_rdata;
        end
    end

    // ****************************************************************
    // Register read
    // ****************************************************************
    always @*
    begin
        next_rdata = `REG_ZERO;
        if (reg_read_in)
        begin
            case (reg_addr_in)
                `ADDR_GLOBAL_CTRL:
                    next_rdata[`BIT_GLOBAL_EN] = global_irq_enable;
                `ADDR_INT_CTRL0:
                begin
                    next_rdata[`BIT_PROT_EN] = protection_irq_enable;
                    next_rdata[`BIT_CONV_EN] = conversion_irq_enable;
                    next_rdata[`BIT_TOUCH_EN] = touch_slot_irq_enable;
                    next_rdata[`BIT_PROT_FLAG] = protection_request_flag;
                    next_rdata[`BIT_CONV_FLAG] = conversion_done_flag;
                    next_rdata[`BIT_TOUCH_FLAG] = touch_slot_request_flag;
                end
                `ADDR_INT_GROUP:
                    next_rdata = {group_request_flag, group_enable};
                `ADDR_INT_LOW_EE:
                begin
                    next_rdata[`BIT_LOW_EN] = low_supply_irq_enable;
                    next_rdata[`BIT_EE_EN] = eeprom_irq_enable;
                    next_rdata[`BIT_LOW_FLAG] = low_supply_request_flag;
                    next_rdata[`BIT_EE_FLAG] = eeprom_write_done_flag;
                end
                `ADDR_TIME_BASE_CTRL:
                    next_rdata = time_base_control;
                `ADDR_INT_INTERVAL:
                begin
                    next_rdata[`BIT_TB0_EN] = interval0_irq_enable;
                    next_rdata[`BIT_TB1_EN] = interval1_irq_enable;
                    next_rdata[`BIT_TB0_FLAG] = interval0_request_flag;
                    next_rdata[`BIT_TB1_FLAG] = interval1_request_flag;
                end
                `ADDR_CORE_STATUS:
                begin
                    next_rdata[`BIT_STACK_FULL] = stack_full_in;
                    next_rdata[`BIT_REQ_PENDING] = pending_any;
                    next_rdata[7:`VEC_LO] = pending_vector;
                end
                default:
                    next_rdata = `REG_ZERO;
            endcase
        end
    end

endmodule

// >>> rtl/irq_tb_defines.vh
/*
 * Register map, field positions, reset values and vector codes of the
 * interrupt request and time base block.
 * Assumes an 8-bit register port with byte-wide registers.
 */
`ifndef IRQ_TB_DEFINES_VH
`define IRQ_TB_DEFINES_VH

// ****************************************************************
// Register addresses
// ****************************************************************
`define ADDR_GLOBAL_CTRL 8'h00
`define ADDR_INT_CTRL0 8'h01
`define ADDR_INT_GROUP 8'h02
`define ADDR_INT_LOW_EE 8'h03
`define ADDR_TIME_BASE_CTRL 8'h04
`define ADDR_INT_INTERVAL 8'h05
`define ADDR_CORE_STATUS 8'h06

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_GLOBAL_EN 0
`define BIT_PROT_EN 0
`define BIT_CONV_EN 1
`define BIT_TOUCH_EN 2
`define BIT_PROT_FLAG 4
`define BIT_CONV_FLAG 5
`define BIT_TOUCH_FLAG 6
`define BIT_LOW_EN 0
`define BIT_EE_EN 1
`define BIT_LOW_FLAG 4
`define BIT_EE_FLAG 5
`define BIT_TB0_EN 0
`define BIT_TB1_EN 1
`define BIT_TB0_FLAG 4
`define BIT_TB1_FLAG 5
`define BIT_TB_ON 7
`define BIT_TB_CK 6
`define BIT_STACK_FULL 0
`define BIT_REQ_PENDING 1
`define FLAG_HI 7
`define FLAG_LO 4
`define EN_HI 3
`define EN_LO 0
`define TB1_SEL_HI 5
`define TB1_SEL_LO 4
`define TB0_SEL_HI 2
`define TB0_SEL_LO 0
`define VEC_LO 4

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define TBC_RESET 8'h37
`define TBC_WRITE_MASK 8'hf7
`define REG_ZERO 8'h00

// ****************************************************************
// Time base divider figures
// ****************************************************************
`define TB0_BASE_EXP 4'h8
`define TB1_BASE_EXP 4'hc
`define TB_CNT_W 15
`define SYS_DIV_LAST 2'h3

// ****************************************************************
// Sources, in priority order; the index is the vector code
// ****************************************************************
`define NUM_SRC 9
`define SRC_PROT 4'h0
`define SRC_CONV 4'h1
`define SRC_TOUCH 4'h2
`define SRC_GROUP0 4'h3
`define SRC_GROUP3 4'h6
`define SRC_TB0 4'h7
`define SRC_TB1 4'h8
`define VEC_NONE 4'hf

`endif

// >>> rtl/interval_divider.v
/*
 * Two time base dividers sharing one input clock and one counter.
 * Assumes the dedicated time base clock is a slow level synchronous to
 * sys_clk_in; a rising level counts as one input clock.
 */
`timescale 1ns/1ps
`include "irq_tb_defines.vh"

module interval_divider (
    input wire sys_clk_in,
    input wire reset_n_in,
    input wire interval_dividers_on_in,
    input wire interval_clock_select_in,
    input wire interval_dedicated_clock_in,
    input wire [2:0] interval0_period_select_in,
    input wire [1:0] interval1_period_select_in,
    output reg interval0_tick_out,
    output reg interval1_tick_out
);

    reg [`TB_CNT_W-1:0] count;
    reg [1:0] sys_div;
    reg dedicated_prev;
    wire input_clock;

    // Mask of the low bits spanned by a period of 2^exp input clocks
    function [`TB_CNT_W-1:0] span_mask;
        input [3:0] exp;
        begin
            span_mask = (15'h7fff >> (4'hf - exp));
        end
    endfunction

    function wraps;
        input [`TB_CNT_W-1:0] cnt;
        input [3:0] exp;
        begin
            wraps = ((cnt & span_mask(exp)) == span_mask(exp));
        end
    endfunction

    // ****************************************************************
    // Input clock selection
    // ****************************************************************
    assign input_clock = interval_clock_select_in ? (sys_div == `SYS_DIV_LAST) :
        (interval_dedicated_clock_in & ~dedicated_prev);

    always @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            count <= 15'h0000;
            sys_div <= 2'h0;
            dedicated_prev <= 1'b0;
            interval0_tick_out <= 1'b0;
            interval1_tick_out <= 1'b0;
        end
        else
        begin
            sys_div <= sys_div + 2'h1;
            dedicated_prev <= interval_dedicated_clock_in;
            // Stopped dividers restart from zero so the first period is whole
            if (!interval_dividers_on_in)
            begin
                count <= 15'h0000;
                interval0_tick_out <= 1'b0;
                interval1_tick_out <= 1'b0;
            end
            else
            begin
                if (input_clock)
                    count <= count + 15'h0001;
                interval0_tick_out <= input_clock &
                    wraps(count, `TB0_BASE_EXP + {1'b0, interval0_period_select_in});
                interval1_tick_out <= input_clock &
                    wraps(count, `TB1_BASE_EXP + {2'b00, interval1_period_select_in});
            end
        end
    end

endmodule

// >>> rtl/irq_priority.v
/*
 * Fixed priority selector over the enabled pending sources.
 * Assumes bit 0 has the highest priority; purely combinational.
 */
`timescale 1ns/1ps
`include "irq_tb_defines.vh"

module irq_priority (
    input wire [`NUM_SRC-1:0] pending_in,
    output reg any_out,
    output reg [3:0] vector_out
);

    integer i;

    always @*
    begin
        any_out = |pending_in;
        vector_out = `VEC_NONE;
        // Walk down so the lowest index wins
        for (i = `NUM_SRC - 1; i >= 0; i = i - 1)
        begin
            if (pending_in[i])
                vector_out = i[3:0];
        end
    end

endmodule

// >>> tb/irq_core_model.sv
/* Core model: takes each offered vector, promptly or after a pause.
   Assumes the request stays up until its acknowledge is taken. */
`timescale 1ns/1ps
module irq_core_model (
    input wire clk_in,
    input wire reset_n_in,
    input wire request_in,
    input wire slow_in,
    output reg ack_out
);
    // ****************
    // Acknowledge
    // ****************
    reg [1:0] wait_cnt;
    always @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ack_out <= 1'b0;
            wait_cnt <= 2'h0;
        end
        else if (request_in && !ack_out && (!slow_in || wait_cnt == 2'h3))
        begin
            // One pulse; a request still up later is taken again
            ack_out <= 1'b1;
            wait_cnt <= 2'h0;
        end
        else
        begin
            ack_out <= 1'b0;
            wait_cnt <= request_in ? wait_cnt + 2'h1 : 2'h0;
        end
    end
endmodule

// >>> tb/irq_time_base_assertions.sv
/* Checker of the interrupt request and time base block.
   Assumes it sees the top module's ports only. */
`timescale 1ns/1ps
module irq_time_base_assertions (
    input wire sys_clk_in,
    input wire reset_n_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_write_in,
    input wire reg_read_in,
    input wire [7:0] reg_rdata_out,
    input wire stack_full_in,
    input wire irq_ack_in,
    input wire return_enable_in,
    input wire irq_request_out,
    input wire [3:0] irq_vector_out
);
    // ****************
    // Port relations
    // ****************
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    wire g_wr = reg_write_in && reg_addr_in == 8'h00;
    stack_block_a: assert property (stack_full_in [*2] |-> !irq_request_out)
        else $error("request while stack full");
    ack_drop_a: assert property (irq_ack_in && irq_request_out |=> !irq_request_out)
        else $error("request kept after ack");
    ack_global_a: assert property (
        irq_ack_in && irq_request_out ##1 !g_wr && !return_enable_in |=> !irq_request_out)
        else $error("global enable kept after ack");
    global_off_a: assert property (
        g_wr && !reg_wdata_in[0] ##1 !g_wr && !return_enable_in |=> !irq_request_out)
        else $error("request with global enable off");
    tbc_read_a: assert property (
        reg_read_in && reg_addr_in == 8'h04 |=> !reg_rdata_out[3])
        else $error("time base bit 3 not zero");
    tbc_write_a: assert property (
        reg_write_in && reg_addr_in == 8'h04 ##1 !reg_write_in ##1 reg_read_in
        && reg_addr_in == 8'h04 |=> reg_rdata_out == ($past(reg_wdata_in, 3) & 8'hf7))
        else $error("time base control readback");
    vec_range_a: assert property (irq_request_out |-> irq_vector_out <= 4'h8)
        else $error("vector out of range");
    req_hold_a: assert property (
        !(reg_write_in || stack_full_in || return_enable_in) [*2] ##0 irq_request_out
        && !irq_ack_in |=> irq_request_out)
        else $error("request dropped before ack");
endmodule
bind irq_time_base irq_time_base_assertions chk (.sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .stack_full_in(stack_full_in), .irq_ack_in(irq_ack_in),
    .return_enable_in(return_enable_in), .irq_request_out(irq_request_out),
    .irq_vector_out(irq_vector_out));

// >>> tb/irq_time_base_bench.sv
/* Self-checking bench of the interrupt request and time base block.
   Assumes the core model answers every offered vector. */
`timescale 1ns/1ps
module irq_time_base_bench;
    // ****************
    // Stimulus
    // ****************
    reg clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, full = 1'b0, slow = 1'b0;
    reg [7:0] addr = 8'h00, wd = 8'h00, ev = 8'h00, r;
    wire [7:0] rdata;
    wire [3:0] vec;
    wire req, wake, ack;
    logic [7:0] exp_q[$];
    int err_count = 0, tests_run = 0, n, ded = 0;
    always #50 clk = ~clk;
    irq_time_base dut (.sys_clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata),
        .protection_fault_in(ev[0]), .conversion_done_in(ev[1]),
        .touch_slot_overflow_in(ev[2]), .eeprom_write_done_in(ev[3]),
        .low_supply_detect_in(ev[4]), .timer_group_event_in(ev[7:5]),
        .interval_dedicated_clock_in(ded[0]), .stack_full_in(full), .irq_ack_in(ack),
        .return_enable_in(1'b0), .irq_request_out(req), .irq_vector_out(vec), .wake_up_out(wake));
    irq_core_model core (.clk_in(clk), .reset_n_in(rst_n), .request_in(req), .slow_in(slow),
        .ack_out(ack));
    task automatic chk(input logic [7:0] got, input string what);
        logic [7:0] e;
        e = exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
        tests_run++;
        if (got !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, e, got);
        end
    endtask
    always @(posedge clk)
    begin
        rd_d <= rd;
        ded <= ded + 1;
        if (rd_d)
            chk(rdata, "read data");
        if (ack && req)
            chk({4'h0, vec}, "vector");
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        if (!w)
            exp_q.push_back(d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic serve(input logic [7:0] v, input logic [7:0] e);
        exp_q.push_back(v);
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= 8'h00;
        for (n = 0; n < 40000 && exp_q.size() > 0; n++)
            @(posedge clk);
        if (n >= 40000)
        begin
            err_count++;
            tally_and_finish();
        end
    endtask
    initial
    begin
        void'($urandom(32'he69311eb));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, 8'h04, 8'h37);
        bus(0, 8'h09, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            slow <= 1'($urandom());
            bus(1, 8'h01, 8'h01 << i);
            bus(1, 8'h00, 8'h01);
            serve(8'(i), 8'h01 << i);
            bus(0, 8'h00, 8'h00);
            bus(0, 8'h01, 8'h01 << i);
        end
        $display("test own vectors done");
        for (int g = 0; g < 3; g++)
        begin
            bus(1, 8'h02, 8'h01 << g);
            bus(1, 8'h00, 8'h01);
            serve(8'(3 + g), 8'h20 << g);
            bus(0, 8'h02, 8'h01 << g);
        end
        for (int j = 0; j < 2; j++)
        begin
            bus(1, 8'h03, 8'h01 << j);
            bus(1, 8'h02, 8'h08);
            bus(1, 8'h00, 8'h01);
            serve(8'h06, j ? 8'h08 : 8'h10);
            bus(0, 8'h03, 8'h11 << j);
            bus(0, 8'h02, 8'h08);
        end
        $display("test groups done");
        for (int k = 0; k < 2; k++)
        begin
            r = (k ? 8'hc0 : 8'h80) | 8'($urandom() % 2);
            bus(1, 8'h05, 8'h01 << k);
            bus(1, 8'h00, 8'h01);
            bus(1, 8'h04, r);
            bus(0, 8'h04, r);
            serve(8'(7 + k), 8'h00);
            bus(1, 8'h04, 8'h40);
            bus(0, 8'h05, k ? 8'h12 : 8'h01);
        end
        $display("test time base done");
        bus(1, 8'h01, 8'h03);
        bus(1, 8'h00, 8'h00);
        ev <= 8'h03;
        @(posedge clk);
        ev <= 8'h00;
        @(posedge clk);
        #1;
        exp_q.push_back(8'h01);
        chk({7'h00, wake}, "wake");
        repeat (8) @(posedge clk);
        full <= 1'b1;
        bus(1, 8'h00, 8'h01);
        repeat (20) @(posedge clk);
        full <= 1'b0;
        slow <= 1'b1;
        serve(8'h00, 8'h00);
        bus(1, 8'h00, 8'h01);
        serve(8'h01, 8'h00);
        $display("test priority done");
        tally_and_finish();
    end
endmodule
